// ===== hw/dcsf_regs.vh
// Constants for one dual-clock FIFO channel with programmable flags.
// Assumes inclusion by the channel module only; definitions only.
//
// Behaviour
// - A word is stored only when both write enables are active.
// - First word after empty becomes readable a few read clocks after writing.
// - Extra first-word latency only applies while the empty flag is low.
// - Almost-full flag updates on write clock edges only.
// - Almost-empty flag updates on read clock edges only.
// - Almost-full goes low once word count reaches depth minus full offset.
// - A write on the almost-full asserting edge leaves depth minus m words.
// - A read on the almost-empty asserting edge leaves n words.
// - Strap low at reset makes the shared pin the offset load strobe.
// - Strap high at reset makes it a second write enable; offsets stay default.
// - Empty and full offsets default to seven words.
// - Full flag low when array full, writes refused, updated on write clock.
// - Empty flag low when pointers equal, reads refused, updated on read clock.
// - Load strobe and read enables low step offset registers onto data out.
`ifndef DCSF_REGS_VH
`define DCSF_REGS_VH

// ==========================================================
// Register port map (write clock domain)
`define DCSF_ADDR_STATUS   2'h0
`define DCSF_ADDR_MASK     2'h1
`define DCSF_ADDR_LEVEL    2'h2
`define DCSF_REG_W         4

// ==========================================================
// Status and mask bit positions
`define DCSF_BIT_FULL      0
`define DCSF_BIT_AFULL     1
`define DCSF_BIT_WR_REFUSE 2
`define DCSF_BIT_RD_REFUSE 3

// ==========================================================
// Level register bit positions
`define DCSF_LVL_FULL_N    0
`define DCSF_LVL_AFULL_N   1
`define DCSF_LVL_LOAD_MODE 2

// ==========================================================
// Offset registers: LSB and MSB words of empty then full offset
`define DCSF_OFF_STEPS     4
`define DCSF_OFF_LO_DEF    9'h007
`define DCSF_OFF_HI_DEF    9'h000
`define DCSF_REG_RESET     4'h0

`endif

// ===== hw/dcsf_gray_sync.v
// Two-flop synchroniser for a gray-coded pointer, with binary output.
// Assumes the gray input changes at most one bit per source clock.
`timescale 1ns/1ps
`default_nettype none

module dcsf_gray_sync #(
  parameter W = 9
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] gray_in,
  output wire [W-1:0] bin_out
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= gray_in;
      sync_reg <= meta_reg;
    end
  end

  // Gray to binary from the second stage only
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bin
      assign bin_out[i] = ^sync_reg[W-1:i];
    end
  endgenerate

endmodule

`default_nettype wire

// ===== hw/dcsf_fifo_channel.v
// One channel of a dual-clock 9-bit FIFO with empty, full and programmable flags.
// Assumes free-running write and read clocks, inputs synchronous to their port clock,
// and offsets loaded only while the FIFO port on the other side is idle.
`timescale 1ns/1ps
`default_nettype none
`include "dcsf_regs.vh"

module dcsf_fifo_channel #(
  parameter AW = 8,
  parameter DW = 9
) (
  input  wire                  rst,
  input  wire                  write_clock_in,
  input  wire                  read_clock_in,
  input  wire [DW-1:0]         data_in,
  input  wire                  write_enable_first_n,
  input  wire                  second_enable_or_load_strobe,
  input  wire                  read_enable_first_n,
  input  wire                  read_enable_second_n,
  output reg  [DW-1:0]         data_out,
  output reg                   full_flag_n,
  output reg                   almost_full_flag_n,
  output reg                   empty_flag_n,
  output reg                   almost_empty_flag_n,
  input  wire [1:0]            reg_addr,
  input  wire [`DCSF_REG_W-1:0] reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output reg  [`DCSF_REG_W-1:0] reg_rdata,
  output reg                   irq
);

  localparam PW = AW + 1;
  localparam [PW-1:0] DEPTH_P = {1'b1, {AW{1'b0}}};

  // ==========================================================
  // Storage and offset registers
  reg  [DW-1:0] mem [0:(1<<AW)-1];
  reg  [DW-1:0] off_mem [0:`DCSF_OFF_STEPS-1];
  wire [2*DW-1:0] empty_off_w = {off_mem[1], off_mem[0]};
  wire [2*DW-1:0] full_off_w  = {off_mem[3], off_mem[2]};
  wire [PW-1:0] empty_off = {1'b0, empty_off_w[AW-1:0]};
  wire [PW-1:0] full_off  = {1'b0, full_off_w[AW-1:0]};

  // ==========================================================
  // Mode strap, caught on each clock while reset is held
  reg load_mode_w;
  reg load_mode_r;

  always @(posedge write_clock_in) begin
    if (rst) begin
      load_mode_w <= ~second_enable_or_load_strobe;
    end
  end

  always @(posedge read_clock_in) begin
    if (rst) begin
      load_mode_r <= ~second_enable_or_load_strobe;
    end
  end

  // ==========================================================
  // Write domain
  reg  [PW-1:0] wptr_reg;
  reg  [PW-1:0] wgray_reg;
  reg  [1:0]    ld_idx_w_reg;
  wire [PW-1:0] rptr_w;
  wire [PW-1:0] rgray;

  wire load_act_w = load_mode_w & ~second_enable_or_load_strobe;
  wire wr_req     = ~write_enable_first_n & second_enable_or_load_strobe;
  wire wr_do      = wr_req & full_flag_n;
  wire ld_wr      = load_act_w & ~write_enable_first_n;

  wire [PW-1:0] wptr_next    = wptr_reg + {{AW{1'b0}}, wr_do};
  wire [PW-1:0] count_w_next = wptr_next - rptr_w;
  wire          full_next    = (count_w_next == DEPTH_P);
  wire          afull_next   = (count_w_next >= DEPTH_P - full_off);

  always @(posedge write_clock_in) begin
    if (wr_do) begin
      mem[wptr_reg[AW-1:0]] <= data_in;
    end
  end

  integer k;
  always @(posedge write_clock_in or posedge rst) begin
    if (rst) begin
      wptr_reg           <= {PW{1'b0}};
      wgray_reg          <= {PW{1'b0}};
      full_flag_n        <= 1'b1;
      almost_full_flag_n <= 1'b1;
      ld_idx_w_reg       <= 2'h0;
      for (k = 0; k < `DCSF_OFF_STEPS; k = k + 1) begin
        off_mem[k] <= (k == 0 || k == 2) ? `DCSF_OFF_LO_DEF : `DCSF_OFF_HI_DEF;
      end
    end else begin
      wptr_reg           <= wptr_next;
      wgray_reg          <= wptr_next ^ (wptr_next >> 1);
      full_flag_n        <= ~full_next;
      almost_full_flag_n <= ~afull_next;
      if (ld_wr) begin
        off_mem[ld_idx_w_reg] <= data_in;
        ld_idx_w_reg          <= ld_idx_w_reg + 2'h1;
      end
    end
  end

  dcsf_gray_sync #(
    .W       (PW)
  ) u_rptr_sync (
    .clk     (write_clock_in),
    .rst     (rst),
    .gray_in (rgray),
    .bin_out (rptr_w)
  );

  // ==========================================================
  // Read domain
  reg  [PW-1:0] rptr_reg;
  reg  [PW-1:0] rgray_reg;
  reg  [1:0]    ld_idx_r_reg;
  reg           rd_refuse_tgl_reg;
  wire [PW-1:0] wptr_r;

  assign rgray = rgray_reg;

  wire rd_en   = ~read_enable_first_n & ~read_enable_second_n;
  wire ld_rd   = load_mode_r & ~second_enable_or_load_strobe & rd_en;
  wire rd_do   = rd_en & ~ld_rd & empty_flag_n;
  wire rd_refd = rd_en & ~ld_rd & ~empty_flag_n;

  wire [PW-1:0] rptr_next    = rptr_reg + {{AW{1'b0}}, rd_do};
  wire [PW-1:0] count_r_next = wptr_r - rptr_next;

  always @(posedge read_clock_in or posedge rst) begin
    if (rst) begin
      rptr_reg            <= {PW{1'b0}};
      rgray_reg           <= {PW{1'b0}};
      empty_flag_n        <= 1'b0;
      almost_empty_flag_n <= 1'b0;
      data_out            <= {DW{1'b0}};
      ld_idx_r_reg        <= 2'h0;
      rd_refuse_tgl_reg   <= 1'b0;
    end else begin
      rptr_reg            <= rptr_next;
      rgray_reg           <= rptr_next ^ (rptr_next >> 1);
      // Word becomes visible only once its pointer has crossed over
      empty_flag_n        <= (count_r_next != {PW{1'b0}});
      almost_empty_flag_n <= (count_r_next > empty_off);
      if (rd_do) begin
        data_out <= mem[rptr_reg[AW-1:0]];
      end else if (ld_rd) begin
        data_out     <= off_mem[ld_idx_r_reg];
        ld_idx_r_reg <= ld_idx_r_reg + 2'h1;
      end
      if (rd_refd) begin
        rd_refuse_tgl_reg <= ~rd_refuse_tgl_reg;
      end
    end
  end

  dcsf_gray_sync #(
    .W       (PW)
  ) u_wptr_sync (
    .clk     (read_clock_in),
    .rst     (rst),
    .gray_in (wgray_reg),
    .bin_out (wptr_r)
  );

  // ==========================================================
  // Refused-read event into the write domain
  reg rd_tgl_meta_reg;
  reg rd_tgl_sync_reg;
  reg rd_tgl_last_reg;

  always @(posedge write_clock_in or posedge rst) begin
    if (rst) begin
      rd_tgl_meta_reg <= 1'b0;
      rd_tgl_sync_reg <= 1'b0;
      rd_tgl_last_reg <= 1'b0;
    end else begin
      rd_tgl_meta_reg <= rd_refuse_tgl_reg;
      rd_tgl_sync_reg <= rd_tgl_meta_reg;
      rd_tgl_last_reg <= rd_tgl_sync_reg;
    end
  end

  // ==========================================================
  // Status, mask and interrupt (write clock domain)
  reg  [`DCSF_REG_W-1:0] status_reg;
  reg  [`DCSF_REG_W-1:0] mask_reg;
  reg  [`DCSF_REG_W-1:0] status_next;
  reg  [`DCSF_REG_W-1:0] mask_next;
  reg  [`DCSF_REG_W-1:0] events;
  reg  [`DCSF_REG_W-1:0] clr;

  always @* begin
    events = {`DCSF_REG_W{1'b0}};
    events[`DCSF_BIT_FULL]      = full_next & full_flag_n;
    events[`DCSF_BIT_AFULL]     = afull_next & almost_full_flag_n;
    events[`DCSF_BIT_WR_REFUSE] = wr_req & ~full_flag_n;
    events[`DCSF_BIT_RD_REFUSE] = rd_tgl_sync_reg ^ rd_tgl_last_reg;
    clr = (reg_wr && reg_addr == `DCSF_ADDR_STATUS) ? reg_wdata : {`DCSF_REG_W{1'b0}};
    // Set wins over a clear in the same cycle
    status_next = (status_reg & ~clr) | events;
    mask_next   = (reg_wr && reg_addr == `DCSF_ADDR_MASK) ? reg_wdata : mask_reg;
  end

  always @(posedge write_clock_in or posedge rst) begin
    if (rst) begin
      status_reg <= `DCSF_REG_RESET;
      mask_reg   <= `DCSF_REG_RESET;
      irq        <= 1'b0;
      reg_rdata  <= `DCSF_REG_RESET;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq        <= |(status_next & mask_next);
      if (reg_rd) begin
        case (reg_addr)
          `DCSF_ADDR_STATUS: begin
            reg_rdata <= status_reg;
          end
          `DCSF_ADDR_MASK: begin
            reg_rdata <= mask_reg;
          end
          `DCSF_ADDR_LEVEL: begin
            reg_rdata <= {1'b0, load_mode_w, almost_full_flag_n, full_flag_n};
          end
          default: begin
            reg_rdata <= `DCSF_REG_RESET;
          end
        endcase
      end else begin
        reg_rdata <= `DCSF_REG_RESET;
      end
    end
  end

endmodule

`default_nettype wire

// ===== verification/dcsf_fifo_channel_properties.sv
// Checker for one FIFO channel: flag moves tied to port strobes.
// Assumes binding to dcsf_fifo_channel; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module dcsf_props #(parameter DW = 9) (
  input wire logic          rst,
  input wire logic          write_clock_in,
  input wire logic          read_clock_in,
  input wire logic          write_enable_first_n,
  input wire logic          second_enable_or_load_strobe,
  input wire logic          read_enable_first_n,
  input wire logic          read_enable_second_n,
  input wire logic [DW-1:0] data_out,
  input wire logic          full_flag_n,
  input wire logic          almost_full_flag_n,
  input wire logic          empty_flag_n,
  input wire logic          almost_empty_flag_n
);
  // ====
  // Read port states
  sequence rd_idle;
    read_enable_first_n || read_enable_second_n;
  endsequence
  sequence rd_shut;
    !empty_flag_n && second_enable_or_load_strobe;
  endsequence
  full_afull_a: assert property (@(posedge write_clock_in) disable iff (rst)
    !full_flag_n |-> !almost_full_flag_n) else $error("full without almost full");
  empty_aempty_a: assert property (@(posedge read_clock_in) disable iff (rst)
    !empty_flag_n |-> !almost_empty_flag_n) else $error("empty without almost empty");
  full_by_write_a: assert property (@(posedge write_clock_in) disable iff (rst)
    $fell(full_flag_n) |-> $past(!write_enable_first_n && second_enable_or_load_strobe))
    else $error("full set without write");
  afull_by_write_a: assert property (@(posedge write_clock_in) disable iff (rst)
    $fell(almost_full_flag_n) |-> $past(!write_enable_first_n && second_enable_or_load_strobe))
    else $error("almost full set without write");
  empty_by_read_a: assert property (@(posedge read_clock_in) disable iff (rst)
    $fell(empty_flag_n) |-> $past(!read_enable_first_n && !read_enable_second_n))
    else $error("empty set without read");
  aempty_by_read_a: assert property (@(posedge read_clock_in) disable iff (rst)
    $fell(almost_empty_flag_n) |-> $past(!read_enable_first_n && !read_enable_second_n))
    else $error("almost empty set without read");
  out_hold_a: assert property (@(posedge read_clock_in) disable iff (rst)
    rd_idle |=> $stable(data_out)) else $error("data out moved without read");
  empty_refuse_a: assert property (@(posedge read_clock_in) disable iff (rst)
    rd_shut |=> $stable(data_out)) else $error("read taken while empty");
endmodule
bind dcsf_fifo_channel dcsf_props #(.DW(DW)) u_dcsf_props (.rst, .write_clock_in,
  .read_clock_in, .write_enable_first_n, .second_enable_or_load_strobe, .read_enable_first_n,
  .read_enable_second_n, .data_out, .full_flag_n, .almost_full_flag_n, .empty_flag_n,
  .almost_empty_flag_n);
`default_nettype wire

// ===== verification/dcsf_reader.sv
// Read-side controller model: drains the channel at a chosen pace.
// Assumes a free read clock; go and slow come from the bench.
`timescale 1ns/1ps
`default_nettype none
module dcsf_reader (
  input  wire logic read_clock_in,
  input  wire logic go,
  input  wire logic slow,
  output var  logic read_enable_first_n,
  output wire logic read_enable_second_n
);
  logic ph = 1'b0;
  initial read_enable_first_n = 1'b1;
  assign read_enable_second_n = 1'b0;
  always @(posedge read_clock_in) begin
    ph <= ~ph;
    read_enable_first_n <= !(go && (!slow || ph));
  end
endmodule
`default_nettype wire

// ===== verification/dcsf_fifo_channel_test.sv
// Testbench for one FIFO channel against a queue model.
// Assumes the design and the read-side model in dcsf_reader.
`timescale 1ns/1ps
`default_nettype none
module dcsf_fifo_channel_test;
  logic        rst = 1'b1, wclk = 1'b0, rclk = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        write_enable_first = 1'b1, pin = 1'b1, go = 1'b0, slow = 1'b0;
  logic        ren1, ren2, ff, af, ef, ae, irq;
  logic [8:0]  din = 9'h000, dout, ex, q[$], off[4];
  logic [1:0]  ad = 2'h0;
  logic [3:0]  wd = 4'h0, rdt, st;
  logic [31:0] seed = 32'h9878EB5E, r;
  int          n_fail = 0, compares = 0, n, m, k, kw, cyc = 0, lat;
  bit          lm, qw, qr, rf, rr, hv;
  initial forever #5 wclk = ~wclk;
  initial forever #7 rclk = ~rclk;
  dcsf_fifo_channel #(.AW(8), .DW(9)) u_dcsf_fifo_channel (.rst(rst), .write_clock_in(wclk),
    .read_clock_in(rclk), .data_in(din), .write_enable_first_n(write_enable_first),
    .second_enable_or_load_strobe(pin), .read_enable_first_n(ren1), .read_enable_second_n(ren2),
    .data_out(dout), .full_flag_n(ff), .almost_full_flag_n(af), .empty_flag_n(ef),
    .almost_empty_flag_n(ae), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdt), .irq(irq));
  dcsf_reader u_dcsf_reader (.read_clock_in(rclk), .go(go), .slow(slow),
    .read_enable_first_n(ren1), .read_enable_second_n(ren2));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string s, logic [8:0] e, logic [8:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rg(bit w, logic [1:0] a, logic [3:0] d);
    ad <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge wclk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 if (!w) chk("reg", {5'h00, d}, {5'h00, rdt});
    @(posedge wclk);
  endtask
  task automatic do_rst(bit s);
    rst <= 1'b1;
    pin <= s;
    q.delete();
    {k, kw, n, m, lm, rf, rr} = {32'd0, 32'd0, 32'd7, 32'd7, !s, 2'b00};
    repeat (12) @(posedge wclk);
    rst <= 1'b0;
    @(posedge wclk);
  endtask
  task automatic drain();
    go <= 1'b1;
    for (int i = 0; i < 3000 && q.size() > 0; i++) @(posedge wclk);
    repeat (20) @(posedge wclk);
    go <= 1'b0;
    repeat (6) @(posedge wclk);
  endtask
  // ====
  // Queue model of both ports
  always @(posedge wclk) if (!rst && !write_enable_first) begin
    if (!pin && lm) begin
      off[kw] = din;
      kw = (kw + 1) % 4;
    end else if (pin && ff) q.push_back(din);
    else if (pin) rf = 1;
    #1 if (qw) chk("full", q.size() != 256, ff);
    if (qw) chk("afull", q.size() < 256 - m, af);
  end
  always @(posedge rclk) if (!rst && !ren1 && !ren2) begin
    hv = 1;
    if (!pin && lm) begin
      ex = off[k];
      k = (k + 1) % 4;
    end else if (ef) ex = q.pop_front();
    else {hv, rr} = 2'b01;
    #1 if (hv) chk("dout", ex, dout);
    if (hv && qr && pin) chk("empty", q.size() != 0, ef);
    if (hv && qr && pin) chk("aempty", q.size() > n, ae);
  end
  always @(posedge wclk) if (++cyc == 20000) begin
    n_fail++;
    conclude();
  end
  initial begin
    do_rst(1'b1);
    qw = 1;
    repeat (800) begin
      r = xs();
      write_enable_first <= r[0];
      pin <= r[1] | r[2];
      din <= r[12:4];
      @(posedge wclk);
    end
    {write_enable_first, pin} <= 2'b11;
    @(posedge wclk);
    // Expected sticky and level bits follow the model's fill, no reads yet
    st = {1'b0, rf, q.size() >= 256 - m, q.size() == 256};
    rg(0, 2'h0, st);
    rg(0, 2'h2, {2'b00, ~st[1:0]});
    rg(1, 2'h3, 4'hF);
    rg(0, 2'h3, 4'h0);
    rg(1, 2'h1, 4'h4);
    chk("irq", rf, irq);
    rg(1, 2'h0, 4'h4);
    chk("irq", 0, irq);
    {qw, qr} = 2'b01;
    slow <= 1'b1;
    drain();
    rg(0, 2'h0, {rr, 1'b0, st[1:0]});
    write_enable_first <= 1'b0;
    @(posedge wclk);
    write_enable_first <= 1'b1;
    #1;
    // Flag is looked at once it has settled after each read edge
    for (lat = 0; ef !== 1'b1 && lat < 8; lat++) begin
      @(posedge rclk);
      #1;
    end
    chk("latency", 1, lat >= 1 && lat <= 3);
    @(posedge wclk);
    drain();
    {qr, go} <= 2'b01;
    repeat (600) begin
      r = xs();
      write_enable_first <= r[0];
      slow <= r[1];
      din <= r[12:4];
      @(posedge wclk);
    end
    write_enable_first <= 1'b1;
    drain();
    do_rst(1'b0);
    for (int i = 0; i < 4; i++) begin
      write_enable_first <= 1'b0;
      din <= (i == 0) ? 9'h003 : (i == 2) ? 9'h005 : 9'h000;
      @(posedge wclk);
    end
    {write_enable_first, slow} <= 2'b10;
    {n, m} = {32'd3, 32'd5};
    go <= 1'b1;
    repeat (8) @(posedge wclk);
    go <= 1'b0;
    repeat (4) @(posedge wclk);
    pin <= 1'b1;
    rg(0, 2'h2, 4'h7);
    qr = 1;
    for (int i = 0; i < 4; i++) begin
      write_enable_first <= 1'b0;
      @(posedge wclk);
      write_enable_first <= 1'b1;
      repeat (10) @(posedge wclk);
      chk("aempty", i == 3, ae);
    end
    conclude();
  end
endmodule
`default_nettype wire
